//--- pkg/spic_pkg.sv
`default_nettype none
package spic_pkg;
	// ------------------------------------------------------------
	// user constant indices
	// ------------------------------------------------------------
	localparam logic [7:0]  SPIC_IDX_SW_ONE     = 8'h01;
	localparam logic [7:0]  SPIC_IDX_SW_TWO     = 8'h02;
	localparam logic [7:0]  SPIC_IDX_FIRST_NUM  = 8'h03;
	localparam logic [7:0]  SPIC_IDX_SPD_REF_GN = 8'h03;
	localparam logic [7:0]  SPIC_IDX_SPD_LOOP   = 8'h04;
	localparam logic [7:0]  SPIC_IDX_JOG        = 8'h10;
	localparam logic [7:0]  SPIC_IDX_LAST       = 8'h2a;
	localparam int          SPIC_DEPTH          = 43;

	// ------------------------------------------------------------
	// switch bit positions
	// ------------------------------------------------------------
	localparam int          SPIC_BIT_INHIBIT    = 15;
	localparam int          SPIC_BIT_CONTACT_SP = 2;
	localparam int          SPIC_BIT_FILTER     = 15;
	localparam int          SPIC_BIT_MON_SRC    = 6;

	// ------------------------------------------------------------
	// reset values and jog limit
	// ------------------------------------------------------------
	localparam logic [15:0] SPIC_SW_RESET       = 16'h0000;
	localparam logic [15:0] SPIC_NUM_RESET      = 16'h0000;
	localparam logic [15:0] SPIC_JOG_RESET      = 16'h01f4;
	localparam logic [15:0] SPIC_JOG_MAX        = 16'h1388;

	// ------------------------------------------------------------
	// filter timing
	// ------------------------------------------------------------
	localparam int          SPIC_CLK_MHZ        = 100;
	localparam int          SPIC_LD_KPPS        = 450;
	localparam int          SPIC_OC_KPPS        = 200;
	localparam int          SPIC_LD_QTR_NS      = 1000000 / (4 * SPIC_LD_KPPS);
	localparam int          SPIC_OC_QTR_NS      = 1000000 / (4 * SPIC_OC_KPPS);
	localparam logic [9:0]  SPIC_LD_CYC         =
		10'(SPIC_LD_QTR_NS * SPIC_CLK_MHZ / 1000);
	localparam logic [9:0]  SPIC_OC_CYC         =
		10'(SPIC_OC_QTR_NS * SPIC_CLK_MHZ / 1000);

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [0:0] {
		SPIC_CTRL_SPEED_TORQUE = 1'b0,
		SPIC_CTRL_POSITION     = 1'b1
	} spic_ctrl_e;

	typedef struct packed {
		logic        en;
		logic [7:0]  index;
		logic [15:0] data;
	} spic_cfg_wr_s;
endpackage
`default_nettype wire

//--- hdl/spic_pulse_filter.sv
`timescale 1ns/1ps
`default_nettype none
module spic_pulse_filter
	import spic_pkg::*;
(
	input  wire logic clock,
	input  wire logic arst_n,
	input  wire logic clk_en,
	input  wire logic open_collector,
	input  wire logic pulse_in,
	output logic      pulse_edge
);
	// ------------------------------------------------------------
	// stability filter
	// ------------------------------------------------------------
	// a level is accepted only after holding for a quarter period of
	// the fastest legal pulse train; slower sources get a longer
	// window for better noise rejection on long open-collector runs
	logic [9:0] cnt_reg;
	logic [9:0] cnt_next;
	logic       level_reg;
	logic       level_next;
	logic       edge_reg;
	logic       edge_next;
	wire  [9:0] limit   = open_collector ? SPIC_OC_CYC : SPIC_LD_CYC;
	wire        differs = pulse_in != level_reg;
	wire        done    = differs && (cnt_reg >= limit - 10'h001);

	assign cnt_next   = (!differs || done) ? 10'h000 : cnt_reg + 10'h001;
	assign level_next = done ? pulse_in : level_reg;
	assign edge_next  = done && pulse_in;
	assign pulse_edge = edge_reg;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg   <= 10'h000;
			level_reg <= 1'b0;
			edge_reg  <= 1'b0;
		end else if (clk_en) begin
			cnt_reg   <= cnt_next;
			level_reg <= level_next;
			edge_reg  <= edge_next;
		end
	end
endmodule
`default_nettype wire

//--- hdl/spic_core.sv
`timescale 1ns/1ps
`default_nettype none
module spic_core
	import spic_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  arst_n,
	input  wire logic                  clk_en,
	input  wire spic_pkg::spic_ctrl_e  control_type,
	input  wire spic_pkg::spic_cfg_wr_s cfg_wr,
	input  wire logic [7:0]            rd_index,
	input  wire logic                  ref_pulse,
	input  wire logic                  ref_dir,
	input  wire logic                  mode_contact_input,
	input  wire logic [15:0]           torque_ref,
	input  wire logic [15:0]           speed_ref,
	output logic [15:0]                rd_data,
	output logic [31:0]                ref_count,
	output logic                       servo_lock,
	output logic                       speed_loop_pi,
	output logic                       filter_open_collector,
	output logic [15:0]                torque_monitor_out,
	output logic [15:0]                speed_monitor_out,
	output logic [15:0]                jog_rate,
	output logic [15:0]                speed_reference_gain,
	output logic [15:0]                speed_loop_gain
);
	// ------------------------------------------------------------
	// constant decode
	// ------------------------------------------------------------
	function automatic logic in_range(input logic [7:0] idx);
		in_range = (idx >= SPIC_IDX_SW_ONE) && (idx <= SPIC_IDX_LAST);
	endfunction

	function automatic logic [5:0] slot(input logic [7:0] idx);
		slot = idx[5:0];
	endfunction

	// ------------------------------------------------------------
	// user constant store
	// ------------------------------------------------------------
	// one word per index; switch words and numbers share the store
	logic [15:0] const_mem [SPIC_DEPTH];
	logic [15:0] rd_data_reg;
	logic [15:0] rd_data_next;
	logic [15:0] wr_value;

	wire wr_ok = cfg_wr.en && in_range(cfg_wr.index);
	wire wr_jog_over = (cfg_wr.index == SPIC_IDX_JOG) &&
		(cfg_wr.data > SPIC_JOG_MAX);
	assign wr_value = wr_jog_over ? SPIC_JOG_MAX : cfg_wr.data;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < SPIC_DEPTH; i++) begin
				const_mem[i] <= (8'(i) == SPIC_IDX_JOG) ? SPIC_JOG_RESET :
					(8'(i) < SPIC_IDX_FIRST_NUM) ? SPIC_SW_RESET :
					SPIC_NUM_RESET;
			end
		end else if (clk_en && wr_ok) begin
			const_mem[slot(cfg_wr.index)] <= wr_value;
		end
	end

	assign rd_data_next = in_range(rd_index) ?
		const_mem[slot(rd_index)] : 16'h0000;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rd_data_reg <= 16'h0000;
		end else if (clk_en) begin
			rd_data_reg <= rd_data_next;
		end
	end
	assign rd_data = rd_data_reg;

	// ------------------------------------------------------------
	// switch fields
	// ------------------------------------------------------------
	wire [15:0] function_switch_word_one = const_mem[slot(SPIC_IDX_SW_ONE)];
	wire [15:0] function_switch_word_two = const_mem[slot(SPIC_IDX_SW_TWO)];
	wire [15:0] jog_speed_setting        = const_mem[slot(SPIC_IDX_JOG)];
	wire pos_mode = control_type == SPIC_CTRL_POSITION;
	wire inhibit_sel  = function_switch_word_one[SPIC_BIT_INHIBIT];
	wire contact_spd  = function_switch_word_two[SPIC_BIT_CONTACT_SP];
	// contact speed control takes the contact away from the inhibit
	wire inhibit_use  = pos_mode && inhibit_sel && !contact_spd;
	wire inhibit_now  = inhibit_use && mode_contact_input;

	assign filter_open_collector =
		function_switch_word_two[SPIC_BIT_FILTER];

	// contact selects P when not claimed by inhibit or contact speed use
	assign speed_loop_pi = inhibit_use || contact_spd ||
		!mode_contact_input;
	assign servo_lock    = inhibit_now;
	assign jog_rate      = jog_speed_setting;

	// numeric constants only mean something under their control type
	assign speed_reference_gain = pos_mode ? 16'h0000 :
		const_mem[slot(SPIC_IDX_SPD_REF_GN)];
	assign speed_loop_gain = pos_mode ?
		const_mem[slot(SPIC_IDX_SPD_LOOP)] : 16'h0000;

	// ------------------------------------------------------------
	// reference pulse counting
	// ------------------------------------------------------------
	logic        pulse_edge;
	logic [31:0] count_reg;
	logic [31:0] count_next;
	logic [15:0] panel_torque_check_reg;
	logic [15:0] panel_torque_check_next;
	logic [15:0] vmon_reg;

	spic_pulse_filter u_filter (
		.clock          (clock),
		.arst_n         (arst_n),
		.clk_en         (clk_en),
		.open_collector (filter_open_collector),
		.pulse_in       (ref_pulse),
		.pulse_edge     (pulse_edge)
	);

	// a pulse landing while inhibited is dropped, not deferred
	wire count_step = pos_mode && pulse_edge && !inhibit_now;
	assign count_next = !count_step ? count_reg :
		ref_dir ? count_reg - 32'h0000_0001 :
		count_reg + 32'h0000_0001;

	// ------------------------------------------------------------
	// monitors
	// ------------------------------------------------------------
	assign panel_torque_check_next = function_switch_word_two[SPIC_BIT_MON_SRC] ?
		speed_ref : torque_ref;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= 32'h0000_0000;
			panel_torque_check_reg  <= 16'h0000;
			vmon_reg  <= 16'h0000;
		end else if (clk_en) begin
			count_reg <= count_next;
			panel_torque_check_reg  <= panel_torque_check_next;
			vmon_reg  <= speed_ref;
		end
	end

	assign ref_count          = count_reg;
	assign torque_monitor_out = panel_torque_check_reg;
	assign speed_monitor_out  = vmon_reg;
endmodule
`default_nettype wire

//--- tb/spic_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
module spic_core_chk
	import spic_pkg::*;
(
	input wire logic                   clock,
	input wire logic                   arst_n,
	input wire logic                   clk_en,
	input wire spic_pkg::spic_ctrl_e   control_type,
	input wire spic_pkg::spic_cfg_wr_s cfg_wr,
	input wire logic                   mode_contact_input,
	input wire logic [15:0]            torque_ref,
	input wire logic [15:0]            speed_ref,
	input wire logic [31:0]            ref_count,
	input wire logic                   servo_lock,
	input wire logic                   speed_loop_pi,
	input wire logic                   filter_open_collector,
	input wire logic [15:0]            torque_monitor_out,
	input wire logic [15:0]            jog_rate,
	input wire logic [15:0]            speed_reference_gain,
	input wire logic [15:0]            speed_loop_gain
);
	// ----
	// shadow of the switch words
	// ----
	logic [15:0] sw1_reg;
	logic [15:0] sw2_reg;
	wire logic        wr  = cfg_wr.en && clk_en;
	wire logic        pos = control_type == SPIC_CTRL_POSITION;
	wire logic        inh = pos && sw1_reg[15] && !sw2_reg[2] &&
		mode_contact_input;
	wire logic [15:0] mon_exp = sw2_reg[6] ? speed_ref : torque_ref;
	wire logic [15:0] jog_exp = (cfg_wr.data > SPIC_JOG_MAX) ? SPIC_JOG_MAX
		: cfg_wr.data;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sw1_reg <= SPIC_SW_RESET;
			sw2_reg <= SPIC_SW_RESET;
		end else if (wr && cfg_wr.index == SPIC_IDX_SW_ONE) begin
			sw1_reg <= cfg_wr.data;
		end else if (wr && cfg_wr.index == SPIC_IDX_SW_TWO) begin
			sw2_reg <= cfg_wr.data;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	// two locked cycles; the count gate uses the same-cycle lock, so no accepted edge is left in flight
	sequence s_locked2; servo_lock ##1 servo_lock; endsequence
	sequence s_speed2; !pos ##1 !pos; endsequence
	lock_follows_a: assert property (servo_lock == inh)
		else $error("servo lock wrong");
	pi_forced_a: assert property (inh |-> speed_loop_pi)
		else $error("speed loop not pi");
	contact_dir_a: assert property (sw2_reg[2] |-> !servo_lock)
		else $error("lock with contact speed mode");
	filter_sel_a: assert property (filter_open_collector == sw2_reg[15])
		else $error("filter select wrong");
	mon_src_a: assert property (clk_en |=>
		torque_monitor_out == $past(mon_exp))
		else $error("monitor source wrong");
	count_hold_a: assert property (s_locked2 |=> $stable(ref_count))
		else $error("count moved while locked");
	speed_hold_a: assert property (s_speed2 |=> $stable(ref_count))
		else $error("count moved in speed mode");
	count_step_a: assert property ($changed(ref_count) |->
		(ref_count - $past(ref_count)) inside {32'h1, 32'hffff_ffff})
		else $error("count step not one");
	jog_clamp_a: assert property (wr && cfg_wr.index == SPIC_IDX_JOG |=>
		jog_rate == $past(jog_exp)) else $error("jog value wrong");
	gain_decode_a: assert property (
		(pos ? speed_reference_gain : speed_loop_gain) == 16'h0)
		else $error("gain decode wrong");
endmodule
bind spic_core spic_core_chk u_chk (.clock(clock), .arst_n(arst_n),
	.clk_en(clk_en), .control_type(control_type), .cfg_wr(cfg_wr),
	.mode_contact_input(mode_contact_input), .torque_ref(torque_ref),
	.speed_ref(speed_ref), .ref_count(ref_count), .servo_lock(servo_lock),
	.speed_loop_pi(speed_loop_pi), .jog_rate(jog_rate),
	.filter_open_collector(filter_open_collector),
	.torque_monitor_out(torque_monitor_out),
	.speed_reference_gain(speed_reference_gain),
	.speed_loop_gain(speed_loop_gain));
`default_nettype wire

//--- tb/spic_host.sv
`timescale 1ns/1ps
`default_nettype none
module spic_host (
	input  wire logic clock,
	output logic      ref_pulse
);
	// high lasts half cycles and low half plus one between pulses, so a short half tests the filter
	task automatic send(input int n, input int half);
		for (int i = 0; i < n; i++) begin
			@(posedge clock) #1 ref_pulse = 1'b1;
			repeat (half) @(posedge clock);
			#1 ref_pulse = 1'b0;
			repeat (half) @(posedge clock);
		end
		// return off the edge so callers never race the design
		#1;
	endtask
	initial ref_pulse = 1'b0;
endmodule
`default_nettype wire

//--- tb/spic_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
module spic_core_bench;
	import spic_pkg::*;
	logic clock = 0, arst_n = 0, clk_en = 1, ref_dir = 0, mci = 1;
	spic_ctrl_e control_type = SPIC_CTRL_POSITION;
	spic_cfg_wr_s cfg_wr = '0;
	logic [7:0] rd_index = 8'h00;
	logic [15:0] torque_ref = 16'h1234, speed_ref = 16'h5678;
	logic [15:0] rd_data, panel_torque_check, smon, jog, sgain, lgain;
	logic [31:0] ref_count, cnt;
	logic ref_pulse, lock, pi, foc;
	int n_mismatch = 0, tests_run = 0;
	always #5 clock = ~clock;
	spic_host u_host (.clock(clock), .ref_pulse(ref_pulse));
	spic_core u_dut (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
		.control_type(control_type), .cfg_wr(cfg_wr), .rd_index(rd_index),
		.ref_pulse(ref_pulse), .ref_dir(ref_dir), .mode_contact_input(mci),
		.torque_ref(torque_ref), .speed_ref(speed_ref), .rd_data(rd_data),
		.ref_count(ref_count), .servo_lock(lock), .speed_loop_pi(pi),
		.filter_open_collector(foc), .torque_monitor_out(panel_torque_check),
		.speed_monitor_out(smon), .jog_rate(jog),
		.speed_reference_gain(sgain), .speed_loop_gain(lgain));
	task automatic stop_test;
		$display("TB: %0d checks, %0d mismatches", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [15:0] d);
		@(posedge clock) #1 cfg_wr = '{1'b1, idx, d};
		@(posedge clock) #1 cfg_wr.en = 1'b0;
	endtask
	task automatic step;
		repeat (2) @(posedge clock);
		#1;
	endtask
	task automatic t_count;
		cnt = 0;
		chk(pi, 0);
		// 80-cycle halves pass the line-driver window, not open-collector
		u_host.send(3, 80); cnt += 3; chk(ref_count, cnt);
		wr(SPIC_IDX_SW_TWO, 16'h8000); chk(foc, 1);
		u_host.send(2, 80); chk(ref_count, cnt);
		u_host.send(2, 140); cnt += 2; chk(ref_count, cnt);
		wr(SPIC_IDX_SW_TWO, 16'h0000);
		control_type = SPIC_CTRL_SPEED_TORQUE;
		u_host.send(1, 80); chk(ref_count, cnt);
		control_type = SPIC_CTRL_POSITION;
	endtask
	task automatic t_inhib;
		wr(SPIC_IDX_SW_ONE, 16'h8000); step;
		chk(lock, 1);
		chk(pi, 1);
		u_host.send(2, 80); chk(ref_count, cnt);
		mci = 0; step; chk(lock, 0);
		u_host.send(2, 80); cnt += 2; chk(ref_count, cnt);
		ref_dir = 1; u_host.send(1, 80); cnt -= 1; chk(ref_count, cnt);
		ref_dir = 0;
		// keep bit 2 clear elsewhere; set here only to see inhibit drop
		wr(SPIC_IDX_SW_TWO, 16'h0004); mci = 1; step; chk(lock, 0);
		wr(SPIC_IDX_SW_TWO, 16'h0000); wr(SPIC_IDX_SW_ONE, 16'h0000);
	endtask
	task automatic t_mon;
		step; chk(panel_torque_check, 16'h1234);
		chk(smon, 16'h5678);
		wr(SPIC_IDX_SW_TWO, 16'h0040); step; chk(panel_torque_check, 16'h5678);
		wr(SPIC_IDX_SW_TWO, 16'h0000);
	endtask
	task automatic t_const;
		wr(SPIC_IDX_JOG, 16'h2000); chk(jog, SPIC_JOG_MAX);
		wr(SPIC_IDX_JOG, 16'h0000); chk(jog, 0);
		wr(SPIC_IDX_SPD_REF_GN, 16'h00aa); wr(SPIC_IDX_SPD_LOOP, 16'h00bb);
		wr(8'h2b, 16'hffff);
		control_type = SPIC_CTRL_SPEED_TORQUE; #1;
		chk(sgain, 16'h00aa); chk(lgain, 0);
		control_type = SPIC_CTRL_POSITION; #1;
		chk(sgain, 0); chk(lgain, 16'h00bb);
		rd_index = SPIC_IDX_SPD_REF_GN; step; chk(rd_data, 16'h00aa);
		rd_index = 8'h2b; step; chk(rd_data, 0);
	endtask
	task automatic t_hold;
		// enable low must freeze stores, filter and monitors alike
		clk_en = 0; torque_ref = 16'h4321;
		wr(SPIC_IDX_JOG, 16'h0100); u_host.send(1, 80);
		chk(jog, 16'h0000);
		chk(ref_count, cnt);
		chk(panel_torque_check, 16'h1234);
		clk_en = 1; step; chk(panel_torque_check, 16'h4321);
	endtask
	initial begin
		repeat (6) @(posedge clock);
		#1 arst_n = 1;
		chk(jog, SPIC_JOG_RESET);
		chk(ref_count, 0);
		t_count; t_inhib; t_mon; t_const; t_hold;
		stop_test;
	end
	// whole run is a few thousand cycles
	initial begin
		#300000;
		n_mismatch++;
		stop_test;
	end
endmodule
`default_nettype wire
